/* hdl/ipr_defs.svh */
// Purpose: Constants for the interrupt priority resolver
// Assumes: 54 sources, 3-bit levels held in 4-bit nibbles
// Notes:   Definitions only
`ifndef IPR_DEFS_SVH
`define IPR_DEFS_SVH

`define IPR_NUM_SRC      54
`define IPR_IDX_W        6
`define IPR_LVL_W        3
`define IPR_NIB_W        4
`define IPR_NIB_PER_REG  4
`define IPR_NUM_REG      14
`define IPR_REG_W        16
`define IPR_REG_AW       4
`define IPR_VEC_W        6
`define IPR_VEC_BASE     6'h08
`define IPR_LVL_MIN      3'h0
`define IPR_RESV_A       6'h29
`define IPR_RESV_B       6'h2a
`define IPR_RESV_LO      6'h2d
`define IPR_RESV_HI      6'h35
`define IPR_CFG_RST      16'h0000

`endif

/* hdl/ipr_pkg.sv */
// Purpose: Types for the interrupt priority resolver
// Assumes: ipr_defs.svh constants
// Notes:   Types only
`include "ipr_defs.svh"
package ipr_pkg;
   typedef logic [`IPR_LVL_W-1:0] ipr_lvl_t;
   typedef logic [`IPR_IDX_W-1:0] ipr_idx_t;
   typedef logic [`IPR_VEC_W-1:0] ipr_vec_t;
   typedef logic [`IPR_REG_W-1:0] ipr_word_t;
endpackage

/* hdl/ipr_cfg_mem.sv */
// Purpose: Storage for the priority configuration registers
// Assumes: One write port, one registered read port
// Notes:   Top bit of every nibble is never stored and reads zero
`timescale 1ns/1ps
`include "ipr_defs.svh"
module ipr_cfg_mem #(
   parameter int NUM_REG = `IPR_NUM_REG
) (
   input  wire logic                       mclk,
   input  wire logic                       rst,
   input  wire logic                       wr_en,
   input  wire logic [`IPR_REG_AW-1:0]     wr_addr,
   input  wire ipr_pkg::ipr_word_t         wr_data,
   input  wire logic [`IPR_REG_AW-1:0]     rd_addr,
   output ipr_pkg::ipr_word_t              rd_data,
   output logic [NUM_REG*`IPR_REG_W-1:0]   cfg_flat
);
   import ipr_pkg::*;

   ipr_word_t mem_r [NUM_REG];
   ipr_word_t rd_data_r;

   function automatic ipr_word_t mask_nibbles(input ipr_word_t w);
      ipr_word_t m;
      m = w;
      for (int n = 0; n < `IPR_NIB_PER_REG; n++) begin
         m[n*`IPR_NIB_W + `IPR_LVL_W] = 1'b0;
      end
      return m;
   endfunction

   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < NUM_REG; i++) begin
            mem_r[i] <= `IPR_CFG_RST;
         end
      end else if (wr_en && (int'(wr_addr) < NUM_REG)) begin
         mem_r[wr_addr] <= mask_nibbles(wr_data);
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rd_data_r <= `IPR_CFG_RST;
      end else if (int'(rd_addr) < NUM_REG) begin
         rd_data_r <= mem_r[rd_addr];
      end else begin
         rd_data_r <= `IPR_CFG_RST;
      end
   end

   assign rd_data = rd_data_r;

   always_comb begin
      for (int i = 0; i < NUM_REG; i++) begin
         cfg_flat[i*`IPR_REG_W +: `IPR_REG_W] = mem_r[i];
      end
   end
endmodule

/* hdl/ipr_resolver.sv */
// Purpose: Interrupt priority resolver: ranks requests, delivers vector and level
// Assumes: Requests and configuration come from logic on mclk
//          Requests are level signals already gated by their enables
// Notes:   One cycle from request to registered winner
//          Configuration word k holds sources 4k to 4k+3, one nibble each
//          Level 0 requests are still presented; masking is the core's job
//          Reserved sources are dropped before the search
//          Search runs in two layers: within each word, then across words

`timescale 1ns/1ps
`include "ipr_defs.svh"
module ipr_resolver #(
   parameter int NUM_SRC = `IPR_NUM_SRC,
   parameter int NUM_REG = `IPR_NUM_REG
) (
   input  wire logic                   mclk,
   input  wire logic                   rst,
   input  wire logic [NUM_SRC-1:0]     irq_req,
   input  wire logic                   cfg_wr_en,
   input  wire logic [`IPR_REG_AW-1:0] cfg_wr_addr,
   input  wire ipr_pkg::ipr_word_t     cfg_wr_data,
   input  wire logic [`IPR_REG_AW-1:0] cfg_rd_addr,
   output ipr_pkg::ipr_word_t          cfg_rd_data,
   output logic                        irq_valid,
   output ipr_pkg::ipr_vec_t           irq_vector,
   output ipr_pkg::ipr_lvl_t           irq_level,
   output ipr_pkg::ipr_idx_t           irq_source
);
   import ipr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Local sizes and signals
   // Four sources share one configuration word, so the search runs per word first
   // Group count rounds up so a part-filled last word still counts
   localparam int NUM_GRP = (NUM_SRC + `IPR_NIB_PER_REG - 1) / `IPR_NIB_PER_REG;

   // Per-source and per-word search state
   logic [NUM_REG*`IPR_REG_W-1:0] cfg_flat;
   logic [NUM_SRC-1:0]            live_req;
   ipr_lvl_t                      src_lvl [NUM_SRC];
   logic                          grp_valid [NUM_GRP];
   ipr_lvl_t                      grp_level [NUM_GRP];
   ipr_idx_t                      grp_source [NUM_GRP];
   logic                          win_valid_nxt;
   ipr_lvl_t                      win_level_nxt;
   ipr_idx_t                      win_source_nxt;
   logic                          irq_valid_r;
   ipr_vec_t                      irq_vector_r;
   ipr_lvl_t                      irq_level_r;
   ipr_idx_t                      irq_source_r;

   ////////////////////////////////////////////////////////////////////////////
   // Configuration storage
   // Reads come back one cycle after the address, from a register
   ipr_cfg_mem #(
      .NUM_REG (NUM_REG)
   ) u_cfg (
      .mclk     (mclk),
      .rst      (rst),
      .wr_en    (cfg_wr_en),
      .wr_addr  (cfg_wr_addr),
      .wr_data  (cfg_wr_data),
      .rd_addr  (cfg_rd_addr),
      .rd_data  (cfg_rd_data),
      .cfg_flat (cfg_flat)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   // The compare helpers serve both search layers
   // Reserved source check
   function automatic logic is_reserved(input ipr_idx_t s);
      logic hit;
      hit = (s == `IPR_RESV_A) || (s == `IPR_RESV_B);
      if ((s >= `IPR_RESV_LO) && (s <= `IPR_RESV_HI)) begin
         hit = 1'b1;
      end
      return hit;
   endfunction

   function automatic ipr_lvl_t level_of(input logic [NUM_REG*`IPR_REG_W-1:0] f, input int s);
      return f[s*`IPR_NIB_W +: `IPR_LVL_W];
   endfunction

   function automatic logic ranks_above(input ipr_lvl_t a, input ipr_lvl_t b);
      return a > b;
   endfunction

   function automatic logic takes_over(input logic cand_v, input ipr_lvl_t cand_l,
                                       input logic held_v, input ipr_lvl_t held_l);
      return cand_v && (!held_v || ranks_above(cand_l, held_l));
   endfunction

   function automatic ipr_vec_t vector_of(input ipr_idx_t s);
      return ipr_vec_t'(s + `IPR_VEC_BASE);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Request qualification
   // Reserved slots are dropped here so that no later stage needs to know them
   // Reserved sources dropped
   always_comb begin
      for (int s = 0; s < NUM_SRC; s++) begin
         live_req[s] = irq_req[s] && !is_reserved(ipr_idx_t'(s));
      end
   end

   always_comb begin
      for (int s = 0; s < NUM_SRC; s++) begin
         src_lvl[s] = level_of(cfg_flat, s);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Search within each configuration word
   // Two layers keep the compare chain short: four sources per word, then the words
   // Lowest index scanned first
   always_comb begin
      int idx;
      idx = 0;
      for (int g = 0; g < NUM_GRP; g++) begin
         grp_valid[g]  = 1'b0;
         grp_level[g]  = `IPR_LVL_MIN;
         grp_source[g] = '0;
         for (int n = 0; n < `IPR_NIB_PER_REG; n++) begin
            idx = g * `IPR_NIB_PER_REG + n;
            if (idx < NUM_SRC) begin
               if (takes_over(live_req[idx], src_lvl[idx], grp_valid[g], grp_level[g])) begin
                  grp_valid[g]  = 1'b1;
                  grp_level[g]  = src_lvl[idx];
                  grp_source[g] = ipr_idx_t'(idx);
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Search across words, lowest word first
   // Level compared first
   always_comb begin
      win_valid_nxt  = 1'b0;
      win_level_nxt  = `IPR_LVL_MIN;
      win_source_nxt = '0;
      for (int g = 0; g < NUM_GRP; g++) begin
         if (takes_over(grp_valid[g], grp_level[g], win_valid_nxt, win_level_nxt)) begin
            win_valid_nxt  = 1'b1;
            win_level_nxt  = grp_level[g];
            win_source_nxt = grp_source[g];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered delivery
   // Outputs fall to zero when nothing is pending, so the core never sees a stale vector
   // Request presence
   always_ff @(posedge mclk) begin
      if (rst) begin
         irq_valid_r <= 1'b0;
      end else begin
         irq_valid_r <= win_valid_nxt;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         irq_level_r <= `IPR_LVL_MIN;
      end else if (win_valid_nxt) begin
         irq_level_r <= win_level_nxt;
      end else begin
         irq_level_r <= `IPR_LVL_MIN;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         irq_source_r <= '0;
      end else if (win_valid_nxt) begin
         irq_source_r <= win_source_nxt;
      end else begin
         irq_source_r <= '0;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         irq_vector_r <= '0;
      end else if (win_valid_nxt) begin
         irq_vector_r <= vector_of(win_source_nxt);
      end else begin
         irq_vector_r <= '0;
      end
   end

   // Top outputs come straight from the flops above
   assign irq_valid  = irq_valid_r;
   assign irq_vector = irq_vector_r;
   assign irq_level  = irq_level_r;
   assign irq_source = irq_source_r;
endmodule

/* verification/ipr_resolver_assertions.sv */
// Purpose: Port checks for ipr_resolver
// Assumes: One cycle from request to winner
// Notes:   Bound below
`timescale 1ns/1ps
`include "ipr_defs.svh"
module ipr_chk #(parameter int NUM_SRC = `IPR_NUM_SRC) (
   input wire logic               mclk,
   input wire logic               rst,
   input wire logic [NUM_SRC-1:0] irq_req,
   input wire ipr_pkg::ipr_word_t cfg_rd_data,
   input wire logic               irq_valid,
   input wire ipr_pkg::ipr_vec_t  irq_vector,
   input wire ipr_pkg::ipr_lvl_t  irq_level,
   input wire ipr_pkg::ipr_idx_t  irq_source
);
   import ipr_pkg::*;
   localparam logic [53:0] OK = 54'h0019ffffffffff;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   logic [NUM_SRC-1:0] req_q;
   always_ff @(posedge mclk) req_q <= irq_req;
   vec_map_a: assert property (irq_valid |-> irq_vector == irq_source + 6'h08) else $error("bad vector");
   resv_src_a: assert property (irq_valid |-> OK[irq_source]) else $error("reserved won");
   no_req_a: assert property (!(|(irq_req & OK)) |=> !irq_valid) else $error("spurious");
   req_out_a: assert property (|(irq_req & OK) |=> irq_valid) else $error("dropped");
   win_pend_a: assert property (irq_valid |-> req_q[irq_source]) else $error("not pending");
   nib_zero_a: assert property ((cfg_rd_data & 16'h8888) == 16'h0000) else $error("top bit set");
   idle_zero_a: assert property (!irq_valid |-> {irq_vector, irq_level} == 9'h000) else $error("idle");
   src0_tie_a: assert property (irq_req[0] |=> irq_source == 6'h00 || irq_level != 3'h0) else $error("tie");
   cover property (irq_valid && irq_level == 3'h7);
   cover property (irq_valid && irq_source == 6'h2c);
   cover property (irq_valid ##1 !irq_valid);
endmodule
bind ipr_resolver ipr_chk #(.NUM_SRC(NUM_SRC)) ipr_chk_inst (.mclk, .rst, .irq_req, .cfg_rd_data,
   .irq_valid, .irq_vector, .irq_level, .irq_source);

/* verification/ipr_core_model.sv */
// Purpose: Core side that takes vectors
// Assumes: Vector valid while irq_valid
// Notes:   Passive
`timescale 1ns/1ps
module ipr_core_model (
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire logic              irq_valid,
   input  wire ipr_pkg::ipr_vec_t irq_vector,
   output ipr_pkg::ipr_vec_t      last_vec
);
   import ipr_pkg::*;
   always_ff @(posedge mclk) begin
      if (rst) last_vec <= '0;
      else if (irq_valid) last_vec <= irq_vector;
   end
endmodule

/* verification/tb_ipr_resolver.sv */
// Purpose: Self-checking bench for ipr_resolver
// Assumes: Outputs one cycle after inputs
// Notes:   Seed 95
`timescale 1ns/1ps
module tb_ipr_resolver;
   import ipr_pkg::*;
   localparam logic [53:0] OK = 54'h0019ffffffffff;
   logic        mclk = 0, rst = 1, cfg_wr_en = 0, irq_valid;
   logic [53:0] irq_req = '0;
   logic [3:0]  cfg_wr_addr = '0, cfg_rd_addr = '0;
   ipr_word_t   cfg_wr_data = '0, cfg_rd_data;
   ipr_vec_t    irq_vector, last_vec, lvx = '0;
   ipr_lvl_t    irq_level;
   ipr_idx_t    irq_source;
   logic [2:0]  lv [56];
   logic [9:0]  ev = '0;
   int          seed = 95, n_fail = 0, tests_run = 0;
   ipr_resolver ipr_resolver_inst (.mclk, .rst, .irq_req, .cfg_wr_en, .cfg_wr_addr, .cfg_wr_data,
      .cfg_rd_addr, .cfg_rd_data, .irq_valid, .irq_vector, .irq_level, .irq_source);
   ipr_core_model ipr_core_model_inst (.mclk, .rst, .irq_valid, .irq_vector, .last_vec);
   initial forever #2 mclk = ~mclk;
   task automatic chk(logic [15:0] s, logic [15:0] e);
      tests_run++;
      if (s !== e) begin
         n_fail++;
         $display("[FAIL] %0t got %h want %h", $time, s, e);
      end
   endtask
   task automatic close_out;
      if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Highest level wins, lowest index on ties
   function automatic logic [9:0] best(logic [53:0] r);
      int b;
      b = -1;
      for (int i = 0; i < 54; i++) if (r[i] && OK[i] && (b < 0 || lv[i] > lv[b])) b = i;
      return (b < 0) ? 10'h000 : {1'b1, 6'(b), lv[b]};
   endfunction
   task automatic cyc(logic [53:0] r);
      @(posedge mclk);
      #1;
      chk(last_vec, lvx);
      chk(irq_valid, ev[9]);
      chk(irq_source, ev[8:3]);
      chk(irq_level, ev[2:0]);
      chk(irq_vector, ev[9] ? ev[8:3] + 6'h08 : 6'h00);
      if (ev[9]) lvx = ev[8:3] + 6'h08;
      irq_req = r;
      ev = best(r);
   endtask
   task automatic wr(logic [3:0] a, ipr_word_t d);
      @(posedge mclk);
      #1;
      irq_req = '0;
      ev = '0;
      cfg_wr_en = 1;
      cfg_wr_addr = a;
      cfg_wr_data = d;
      if (a < 14) for (int n = 0; n < 4; n++) lv[4*a+n] = d[4*n+:3];
      @(posedge mclk);
      #1;
      cfg_wr_en = 0;
   endtask
   task automatic rd(logic [3:0] a);
      @(posedge mclk);
      #1;
      cfg_rd_addr = a;
      @(posedge mclk);
      #1;
      chk(cfg_rd_data, a < 14 ? {1'b0, lv[4*a+3], 1'b0, lv[4*a+2], 1'b0, lv[4*a+1], 1'b0, lv[4*a]} : 16'h0);
   endtask
   initial begin
      foreach (lv[i]) lv[i] = 3'h0;
      repeat (2) @(posedge mclk);
      #1;
      rst = 0;
      for (int a = 0; a < 16; a++) wr(a[3:0], 16'($random(seed)));
      for (int a = 0; a < 16; a++) rd(a[3:0]);
      repeat (400) cyc(54'({$random(seed), $random(seed)} & {$random(seed), $random(seed)}));
      cyc('1);
      cyc(~OK);
      cyc('0);
      for (int k = 0; k < 2; k++) begin
         for (int a = 0; a < 14; a++) wr(a[3:0], k ? (a == 11 ? 16'h0007 : 16'h0000) : 16'hffff);
         rd(4'h0);
         cyc('1);
         cyc('0);
      end
      close_out;
   end
   initial begin
      #100000;
      n_fail++;
      close_out;
   end
endmodule
